// ---- rtl/csrs_core.v ----
// csrs_core.v: core special-function registers, indirect/banked data access, status flags
// assumes the execution unit issues at most one data access per cycle; memory reads are
// registered into o_rdata one cycle after i_rd, from the bank arrays held here
`include "csrs_defines.vh"
module csrs_core #(
  parameter PC_WIDTH = 11,
  parameter GP_DEPTH = 128
) (
  // clock and reset
  input wire i_mclk,
  input wire i_srst,
  input wire i_por,
  input wire i_wdt_pd_reset,
  // data access from the execution unit
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // alu result path
  input wire i_alu_valid,
  input wire [2:0] i_alu_op,
  input wire [7:0] i_alu_a,
  input wire [7:0] i_alu_b,
  input wire i_alu_to_acc,
  input wire [7:0] i_alu_logic,
  input wire i_rot_carry,
  input wire i_rot_carry_valid,
  // system events
  input wire i_watchdog_clear_instruction,
  input wire i_halt,
  input wire i_wdt_timeout,
  // table read
  input wire i_tbl_rd,
  input wire [15:0] i_rom_word,
  output reg [15:0] o_rom_addr,
  output reg [7:0] o_tbl_low,
  output reg o_tbl_low_valid,
  // program counter low
  output reg o_pcl_jump,
  output reg [PC_WIDTH-1:0] o_pc_jump_target,
  output reg o_dummy_cycle,
  input wire [PC_WIDTH-1:0] i_pc,
  // state views
  output reg [7:0] o_acc,
  output reg [7:0] o_flags,
  output reg o_bank
);
  reg [7:0] ptr0;
  reg [7:0] ptr1;
  reg bank;
  reg [7:0] acc;
  reg [7:0] table_pointer_low;
  reg [7:0] table_pointer_high;
  reg [7:0] table_high_byte;
  reg [7:0] flags;
  reg [7:0] gp0 [0:GP_DEPTH-1];
  reg [7:0] gp1 [0:GP_DEPTH-1];

  // true for an address inside the general purpose area
  function is_gp;
    input [7:0] a;
    begin
      is_gp = (a >= `CSRS_GP_BASE);
    end
  endfunction

  // resolve the effective address and bank of an access
  reg [7:0] eff_addr;
  reg eff_bank;
  reg ind_null;
  always @* begin
    eff_addr = i_addr;
    eff_bank = 1'b0;
    ind_null = 1'b0;
    if (i_addr == `CSRS_ADDR_IND0) begin
      eff_addr = ptr0;
      eff_bank = 1'b0;
    end else if (i_addr == `CSRS_ADDR_IND1) begin
      eff_addr = ptr1;
      eff_bank = bank;
    end
    if ((i_addr == `CSRS_ADDR_IND0 || i_addr == `CSRS_ADDR_IND1) &&
        (eff_addr == `CSRS_ADDR_IND0 || eff_addr == `CSRS_ADDR_IND1)) begin
      ind_null = 1'b1;
    end
  end

  wire [6:0] gp_idx = eff_addr[6:0];

  // read mux; special addresses ignore bank
  reg [7:0] rd_val;
  always @* begin
    rd_val = `CSRS_ZERO;
    if (ind_null) begin
      rd_val = `CSRS_ZERO;
    end else if (is_gp(eff_addr)) begin
      rd_val = eff_bank ? gp1[gp_idx] : gp0[gp_idx];
    end else begin
      case (eff_addr)
        `CSRS_ADDR_PTR0: rd_val = ptr0;
        `CSRS_ADDR_PTR1: rd_val = ptr1;
        `CSRS_ADDR_BANK: rd_val = {7'h00, bank};
        `CSRS_ADDR_ACC: rd_val = acc;
        `CSRS_ADDR_PCL: rd_val = i_pc[7:0];
        `CSRS_ADDR_TABLE_POINTER_LOW: rd_val = table_pointer_low;
        `CSRS_ADDR_TABLE_HIGH_BYTE: rd_val = table_high_byte;
        `CSRS_ADDR_TABLE_POINTER_HIGH: rd_val = table_pointer_high;
        `CSRS_ADDR_FLAGS: rd_val = flags;
        default: rd_val = `CSRS_ZERO;
      endcase
    end
  end

  wire wr_ok = i_wr & ~ind_null;
  wire wr_spec = wr_ok & ~is_gp(eff_addr);

  // general purpose storage; no reset, contents volatile
  always @(posedge i_mclk) begin
    if (wr_ok && is_gp(eff_addr)) begin
      if (eff_bank) begin
        gp1[gp_idx] <= i_wdata;
      end else begin
        gp0[gp_idx] <= i_wdata;
      end
    end
  end

  // alu flag computation
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] res;
  reg carry7;
  reg next_ov;
  reg arith;
  reg is_sub;
  always @* begin
    is_sub = (i_alu_op == `CSRS_OP_SUB) || (i_alu_op == `CSRS_OP_SBC);
    arith = is_sub || (i_alu_op == `CSRS_OP_ADD) || (i_alu_op == `CSRS_OP_ADC);
    sum = 9'h000;
    nib = 5'h00;
    carry7 = 1'b0;
    res = i_alu_logic;
    // subtract as a plus inverted b plus carry-in; carry out means no borrow
    if (arith) begin
      sum = {1'b0, i_alu_a} + {1'b0, (is_sub ? ~i_alu_b : i_alu_b)} +
            {8'h00, ((i_alu_op == `CSRS_OP_SUB) ? 1'b1 :
             ((i_alu_op == `CSRS_OP_ADD) ? 1'b0 : flags[`CSRS_BIT_C]))};
      nib = {1'b0, i_alu_a[3:0]} + {1'b0, (is_sub ? ~i_alu_b[3:0] : i_alu_b[3:0])} +
            {4'h0, sum[0] ^ i_alu_a[0] ^ (is_sub ? ~i_alu_b[0] : i_alu_b[0])};
      carry7 = sum[7] ^ i_alu_a[7] ^ (is_sub ? ~i_alu_b[7] : i_alu_b[7]);
      res = sum[7:0];
    end
    next_ov = carry7 ^ sum[8];
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      // watchdog wake from power-down keeps the bank
      if (!i_wdt_pd_reset) begin
        bank <= 1'b0;
      end
      ptr0 <= `CSRS_ZERO;
      ptr1 <= `CSRS_ZERO;
      acc <= `CSRS_ZERO;
      table_pointer_low <= `CSRS_ZERO;
      table_pointer_high <= `CSRS_ZERO;
      table_high_byte <= `CSRS_ZERO;
      if (i_por) begin
        flags <= `CSRS_ZERO;
      end
      o_rdata <= `CSRS_ZERO;
      o_rom_addr <= 16'h0000;
      o_tbl_low <= `CSRS_ZERO;
      o_tbl_low_valid <= 1'b0;
      o_pcl_jump <= 1'b0;
      o_pc_jump_target <= {PC_WIDTH{1'b0}};
      o_dummy_cycle <= 1'b0;
      o_acc <= `CSRS_ZERO;
      o_flags <= `CSRS_ZERO;
      o_bank <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_val : `CSRS_ZERO;
      // special register writes
      if (wr_spec) begin
        case (eff_addr)
          `CSRS_ADDR_PTR0: ptr0 <= i_wdata;
          `CSRS_ADDR_PTR1: ptr1 <= i_wdata;
          `CSRS_ADDR_BANK: bank <= i_wdata[0];
          `CSRS_ADDR_ACC: acc <= i_wdata;
          `CSRS_ADDR_TABLE_POINTER_LOW: table_pointer_low <= i_wdata;
          `CSRS_ADDR_TABLE_HIGH_BYTE: table_high_byte <= i_wdata;
          `CSRS_ADDR_TABLE_POINTER_HIGH: table_pointer_high <= i_wdata;
          `CSRS_ADDR_FLAGS:
            flags <= (flags & ~`CSRS_FLAGS_WMASK) | (i_wdata & `CSRS_FLAGS_WMASK);
          default: ;
        endcase
      end
      // page-local jump, one dummy cycle
      o_pcl_jump <= wr_spec && (eff_addr == `CSRS_ADDR_PCL);
      o_dummy_cycle <= wr_spec && (eff_addr == `CSRS_ADDR_PCL);
      o_pc_jump_target <= {i_pc[PC_WIDTH-1:8], i_wdata};
      // results land only in the accumulator
      if (i_alu_valid && i_alu_to_acc) begin
        acc <= res;
      end
      // alu updates win over a software flag write in the same cycle
      if (i_alu_valid && arith) begin
        flags[`CSRS_BIT_C] <= sum[8];
        flags[`CSRS_BIT_AC] <= nib[4];
        flags[`CSRS_BIT_OV] <= next_ov;
        flags[`CSRS_BIT_Z] <= (res == 8'h00);
        flags[`CSRS_BIT_SC] <= next_ov ^ res[7];
        if (i_alu_op == `CSRS_OP_SUB) begin
          flags[`CSRS_BIT_CZ] <= (res == 8'h00);
        end else if (i_alu_op == `CSRS_OP_SBC) begin
          flags[`CSRS_BIT_CZ] <= flags[`CSRS_BIT_CZ] & (res == 8'h00);
        end
      end else if (i_alu_valid && i_alu_op == `CSRS_OP_LOGIC) begin
        flags[`CSRS_BIT_Z] <= (res == 8'h00);
      end
      if (i_rot_carry_valid) begin
        flags[`CSRS_BIT_C] <= i_rot_carry;
      end
      // system flags; timeout set wins over clears
      if (i_halt) begin
        flags[`CSRS_BIT_PDF] <= 1'b1;
      end else if (i_watchdog_clear_instruction) begin
        flags[`CSRS_BIT_PDF] <= 1'b0;
      end
      if (i_wdt_timeout) begin
        flags[`CSRS_BIT_TO] <= 1'b1;
      end else if (i_watchdog_clear_instruction || i_halt) begin
        flags[`CSRS_BIT_TO] <= 1'b0;
      end
      // table read: high byte kept, low byte handed out
      o_rom_addr <= {table_pointer_high, table_pointer_low};
      o_tbl_low_valid <= i_tbl_rd;
      if (i_tbl_rd) begin
        table_high_byte <= i_rom_word[15:8];
        o_tbl_low <= i_rom_word[7:0];
      end
      o_acc <= acc;
      o_flags <= flags;
      o_bank <= bank;
    end
  end
endmodule // csrs_core

// ---- rtl/csrs_defines.vh ----
// csrs_defines.vh: addresses, field positions and reset values for the core register set
// assumes inclusion by csrs_core.v only
`ifndef CSRS_DEFINES_VH
`define CSRS_DEFINES_VH
`define CSRS_ADDR_IND0 8'h00
`define CSRS_ADDR_PTR0 8'h01
`define CSRS_ADDR_IND1 8'h02
`define CSRS_ADDR_PTR1 8'h03
`define CSRS_ADDR_BANK 8'h04
`define CSRS_ADDR_ACC 8'h05
`define CSRS_ADDR_PCL 8'h06
`define CSRS_ADDR_TABLE_POINTER_LOW 8'h07
`define CSRS_ADDR_TABLE_HIGH_BYTE 8'h08
`define CSRS_ADDR_TABLE_POINTER_HIGH 8'h09
`define CSRS_ADDR_FLAGS 8'h0A
`define CSRS_GP_BASE 8'h80
`define CSRS_BIT_C 0
`define CSRS_BIT_AC 1
`define CSRS_BIT_Z 2
`define CSRS_BIT_OV 3
`define CSRS_BIT_PDF 4
`define CSRS_BIT_TO 5
`define CSRS_BIT_CZ 6
`define CSRS_BIT_SC 7
`define CSRS_FLAGS_WMASK 8'h0F
`define CSRS_BANK_RESET 8'h00
`define CSRS_ZERO 8'h00
`define CSRS_OP_NONE 3'h0
`define CSRS_OP_ADD 3'h1
`define CSRS_OP_SUB 3'h2
`define CSRS_OP_SBC 3'h3
`define CSRS_OP_LOGIC 3'h4
`define CSRS_OP_ROTC 3'h5
`define CSRS_OP_ADC 3'h6
`endif

// ---- verification/csrs_core_properties.sv ----
// csrs_core_properties.sv: port assertions for csrs_core
// assumes one clock domain, i_srst synchronous active high
module csrs_chk #(
  parameter PC_WIDTH = 11
) (
  // clock, reset and requests
  input wire i_mclk,
  input wire i_srst,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_alu_valid,
  input wire i_watchdog_clear_instruction,
  input wire i_halt,
  input wire i_wdt_timeout,
  // design outputs
  input wire [7:0] o_rdata,
  input wire o_pcl_jump,
  input wire [PC_WIDTH-1:0] o_pc_jump_target,
  input wire o_dummy_cycle,
  input wire [7:0] o_flags
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic [7:0] wd1;
  logic [7:0] wd2;
  // o_flags trails a write by two edges
  always @(posedge i_mclk) begin
    wd1 <= i_wdata;
    wd2 <= wd1;
  end
  property p_unused; i_rd && i_addr > 8'h0A && i_addr < 8'h80 |=> o_rdata == 8'h00; endproperty
  a_unused: assert property (p_unused) else $error("unused read nonzero");
  property p_bank_hi; i_rd && i_addr == 8'h04 |=> o_rdata[7:1] == 7'h00; endproperty
  a_bank_hi: assert property (p_bank_hi) else $error("bank upper bits set");
  property p_pcl;
    i_wr && i_addr == 8'h06 |=> o_pcl_jump && o_pc_jump_target[7:0] == $past(i_wdata);
  endproperty
  a_pcl: assert property (p_pcl) else $error("pcl jump wrong");
  property p_dummy; i_wr && i_addr == 8'h06 |=> o_dummy_cycle; endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy cycle");
  // bit 0 left out: a same-cycle rotate may own the carry
  property p_fwr; i_wr && i_addr == 8'h0A && !i_alu_valid |-> ##2 o_flags[3:1] == wd2[3:1]; endproperty
  a_fwr: assert property (p_fwr) else $error("flag write lost");
  property p_halt; i_halt |-> ##2 o_flags[4]; endproperty
  a_halt: assert property (p_halt) else $error("halt left pdf clear");
  property p_to; i_wdt_timeout |-> ##2 o_flags[5]; endproperty
  a_to: assert property (p_to) else $error("timeout flag clear");
  property p_clr; i_watchdog_clear_instruction && !i_halt && !i_wdt_timeout |-> ##2 o_flags[5:4] == 2'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear left flags");
  cover property (i_halt);
  cover property (i_wr && i_addr == 8'h06);
  cover property (i_rd && i_addr == 8'h02);
endmodule // csrs_chk

bind csrs_core csrs_chk #(.PC_WIDTH(PC_WIDTH)) u_chk (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_rd(i_rd), .i_wr(i_wr), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_alu_valid(i_alu_valid), .i_watchdog_clear_instruction(i_watchdog_clear_instruction), .i_halt(i_halt),
  .i_wdt_timeout(i_wdt_timeout), .o_rdata(o_rdata), .o_pcl_jump(o_pcl_jump),
  .o_pc_jump_target(o_pc_jump_target), .o_dummy_cycle(o_dummy_cycle), .o_flags(o_flags)
);

// ---- verification/csrs_rom_model.sv ----
// csrs_rom_model.sv: program memory behind the table read path
// assumes the core presents a steady address before the read pulse
module csrs_rom_model (
  input wire [15:0] i_rom_addr,
  output logic [15:0] o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // bytes differ so a swapped half shows
  assign o_word = {i_rom_addr[7:0] ^ 8'h5A, i_rom_addr[15:8]};
endmodule // csrs_rom_model

// ---- verification/csrs_core_bench.sv ----
// csrs_core_bench.sv: directed tests of csrs_core via its data port
// assumes csrs_rom_model on the table path and the bound checker
module csrs_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'h0, i_srst = 1'h1, i_por = 1'h1, i_pd = 1'h0, i_rd = 1'h0, i_wr = 1'h0;
  logic i_av = 1'h0, i_rv = 1'h0, i_clr = 1'h0, i_halt = 1'h0, i_to = 1'h0, i_tbl = 1'h0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_a = 8'h00, i_b = 8'h00;
  logic [2:0] i_op = 3'h0;
  wire [15:0] rom_word, rom_addr;
  wire [7:0] o_rdata, o_tbl_low;
  wire [10:0] o_tgt;
  wire o_tbl_v, o_jump, o_dummy;
  wire [7:0] o_acc, o_flags;
  wire o_bank;
  int miscompares = 0, n_checks = 0, cyc = 0;
  always #2 i_mclk = ~i_mclk;
  csrs_core u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_por(i_por), .i_wdt_pd_reset(i_pd),
    .i_rd(i_rd), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_alu_valid(i_av), .i_alu_op(i_op), .i_alu_a(i_a), .i_alu_b(i_b), .i_alu_to_acc(1'h1),
    .i_alu_logic(i_a), .i_rot_carry(1'h0), .i_rot_carry_valid(i_rv), .i_watchdog_clear_instruction(i_clr),
    .i_halt(i_halt), .i_wdt_timeout(i_to), .i_tbl_rd(i_tbl), .i_rom_word(rom_word),
    .o_rom_addr(rom_addr), .o_tbl_low(o_tbl_low), .o_tbl_low_valid(o_tbl_v),
    .o_pcl_jump(o_jump), .o_pc_jump_target(o_tgt), .o_dummy_cycle(o_dummy),
    .i_pc(11'h5A3), .o_acc(o_acc), .o_flags(o_flags), .o_bank(o_bank));
  csrs_rom_model u_rom (.i_rom_addr(rom_addr), .o_word(rom_word));
  task automatic chk(input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_mclk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, e, m);
    @(posedge i_mclk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'h0;
    #1 chk(o_rdata & m, e);
  endtask
  // one-cycle event: 3 halt, 2 timeout, 1 clear, 0 table read
  task automatic ev(input int k);
    @(posedge i_mclk);
    {i_halt, i_to, i_clr, i_tbl} <= 4'h1 << k;
    @(posedge i_mclk);
    {i_halt, i_to, i_clr, i_tbl} <= 4'h0;
  endtask
  task automatic alu(input logic [2:0] op, input logic [7:0] a, b);
    @(posedge i_mclk);
    i_av <= 1'h1;
    i_rv <= op == 3'h5;
    i_op <= op;
    i_a <= a;
    i_b <= b;
    @(posedge i_mclk);
    i_av <= 1'h0;
    i_rv <= 1'h0;
  endtask
  task automatic rst(input logic por, pd);
    @(posedge i_mclk);
    i_srst <= 1'h1;
    i_por <= por;
    i_pd <= pd;
    repeat (3) @(posedge i_mclk);
    i_srst <= 1'h0;
    i_por <= 1'h0;
    i_pd <= 1'h0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // tests need under 120 cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    rst(1'h1, 1'h0);
    rd(8'h04, 8'h00, 8'hFF);
    rd(8'h0A, 8'h00, 8'h30);
    wr(8'h01, 8'h85);
    rd(8'h01, 8'h85, 8'hFF);
    wr(8'h00, 8'h3C);
    rd(8'h85, 8'h3C, 8'hFF);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h01, 8'hFF);
    wr(8'h03, 8'h85);
    wr(8'h02, 8'hC3);
    rd(8'h85, 8'h3C, 8'hFF);
    rd(8'h02, 8'hC3, 8'hFF);
    rd(8'h00, 8'h3C, 8'hFF);
    rd(8'h01, 8'h85, 8'hFF);
    wr(8'h01, 8'h02);
    wr(8'h00, 8'h77);
    rd(8'h00, 8'h00, 8'hFF);
    rd(8'h02, 8'hC3, 8'hFF);
    rd(8'h0B, 8'h00, 8'hFF);
    rd(8'h7F, 8'h00, 8'hFF);
    $display("test memory done");
    wr(8'h06, 8'h3C);
    #1 chk({o_dummy, o_jump, o_tgt}, {2'h3, 11'h53C});
    wr(8'h07, 8'h12);
    wr(8'h09, 8'h34);
    ev(0);
    #1 chk({o_tbl_v, o_tbl_low}, {1'h1, 8'h34});
    rd(8'h08, 8'h48, 8'hFF);
    $display("test jump and table done");
    ev(3);
    rd(8'h0A, 8'h10, 8'h30);
    ev(2);
    rd(8'h0A, 8'h30, 8'h30);
    wr(8'h0A, 8'hCF);
    rd(8'h0A, 8'h3F, 8'hFF);
    rst(1'h0, 1'h1);
    rd(8'h04, 8'h01, 8'hFF);
    chk(o_bank, 1'h1);
    rst(1'h0, 1'h0);
    rd(8'h04, 8'h00, 8'hFF);
    rd(8'h0A, 8'h30, 8'h30);
    ev(1);
    rd(8'h0A, 8'h00, 8'h30);
    $display("test system flags done");
    alu(3'h1, 8'h7F, 8'h01);
    rd(8'h0A, 8'h0A, 8'hCF);
    rd(8'h05, 8'h80, 8'hFF);
    chk({o_acc, o_flags & 8'hCF}, {8'h80, 8'h0A});
    alu(3'h1, 8'h80, 8'h80);
    rd(8'h0A, 8'h8D, 8'hCF);
    alu(3'h2, 8'h05, 8'h05);
    rd(8'h0A, 8'h47, 8'hCF);
    alu(3'h3, 8'h04, 8'h03);
    rd(8'h0A, 8'h03, 8'hCF);
    alu(3'h3, 8'h03, 8'h03);
    rd(8'h0A, 8'h07, 8'hCF);
    alu(3'h4, 8'h00, 8'h00);
    rd(8'h0A, 8'h04, 8'h44);
    alu(3'h5, 8'h81, 8'h00);
    rd(8'h0A, 8'h00, 8'h01);
    // nothing saves the flags for software; the view still shows the last result
    chk(o_flags & 8'h05, 8'h04);
    $display("test alu flags done");
    final_report;
  end
endmodule // csrs_core_bench
